// ==== mei_host_model.sv ====
// Purpose: Host processor model: register bus master and interrupt pin wires
// Assumes: The slave answers by dropping waitrequest; requests start after an edge
// Notes: Pins carry bus keepers, so a released pin holds its last driven level
`default_nettype none
module mei_host_model (
    input wire logic mclk_i,
    input wire logic wait_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] pin_i,
    input wire logic [1:0] oe_i,
    output logic [7:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] wdata_o,
    output logic [1:0] wire_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] keep;
    initial begin
        address_o = 8'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        wdata_o = 32'h0000_0000;
    end
    always_ff @(posedge mclk_i) begin
        keep <= wire_o;
    end
    assign wire_o = (oe_i & pin_i) | (~oe_i & keep);
    // ----------------------------------------------------------------
    // Bus access
    // ----------------------------------------------------------------
    // Request stands until a rising edge samples waitrequest low; data is taken there
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge mclk_i);
        address_o <= a;
        read_o <= ~wr;
        write_o <= wr;
        wdata_o <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wait_i !== 1'b0 && n < 64);
        ok = (wait_i === 1'b0);
        q = rdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
    task automatic arm_wake(output logic ok);
        logic [31:0] q;
        xfer(1'b1, mei_pkg::REG_POWER, 32'h0000_0001, q, ok);
    endtask
    // Instant-on is only reachable again by passing through measurement
    task automatic arm_instant(input logic sel, output logic ok);
        logic [31:0] q;
        logic ok1;
        xfer(1'b1, mei_pkg::REG_POWER, 32'h0000_0003, q, ok1);
        xfer(1'b1, mei_pkg::REG_POWER, {29'h0000_0000, sel, 2'b10}, q, ok);
        ok = ok & ok1;
    endtask
endmodule
`default_nettype wire

// ==== mei_pkg.sv ====
// Purpose: Shared constants and types for the motion event interrupt logic
// Assumes: 32-bit Avalon-MM register bus, byte addresses on word boundaries
// Notes: Only the device status register offset is fixed; other offsets are local
`default_nettype none
package mei_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] REG_DEV_STATUS = 8'h04;
    localparam logic [7:0] REG_EVT_STATUS = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_WARN_THR = 8'h10;
    localparam logic [7:0] REG_ACT_CFG = 8'h20;
    localparam logic [7:0] REG_PIN_ONE = 8'h24;
    localparam logic [7:0] REG_PIN_TWO = 8'h28;
    localparam logic [7:0] REG_POWER = 8'h2C;
    localparam logic [7:0] REG_TIMING = 8'h30;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    // Status bits
    localparam int ST_RDY = 0;
    localparam int ST_ACT = 1;
    localparam int ST_STILL = 2;
    localparam int ST_WARN = 3;
    localparam int ST_AWAKE = 4;
    // Route register: source enables plus polarity
    localparam int RT_RDY = 0;
    localparam int RT_ACT = 1;
    localparam int RT_STILL = 2;
    localparam int RT_WARN = 3;
    localparam int RT_AWAKE = 4;
    localparam int RT_LOW = 7;
    // Activity config: link mode [1:0], ref [2], act timer zero [3], still timer zero [4]
    localparam int CF_REF = 2;
    localparam int CF_ACT_T0 = 3;
    localparam int CF_STILL_T0 = 4;
    // Power control: mode [1:0], impact level [2]
    localparam int PW_IMPACT = 2;
    // Timing
    localparam int TM_EXTCLK = 1;
    localparam int TM_SYNC = 0;

    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [11:0] ZERO12 = 12'h000;

    typedef enum logic [1:0] {
        MEI_PW_STANDBY = 2'b00,
        MEI_PW_WAKEUP = 2'b01,
        MEI_PW_INSTANT = 2'b10,
        MEI_PW_MEASURE = 2'b11
    } mei_power_e;

    typedef enum logic [1:0] {
        MEI_LK_DEFAULT = 2'b00,
        MEI_LK_LINKED = 2'b01,
        MEI_LK_LOOP = 2'b10,
        MEI_LK_AUTOSLEEP = 2'b11
    } mei_link_e;

    typedef enum logic [0:0] {
        MEI_SEEK_ACT = 1'b0,
        MEI_SEEK_STILL = 1'b1
    } mei_seek_e;

    // Detector results for one sample
    typedef struct packed {
        logic act;
        logic still;
        logic impact_lo;
        logic impact_hi;
        logic [11:0] mag;
    } mei_det_s;

    typedef struct packed {
        logic [2:0] rst_sync;
        logic [7:0] warn_thr;
        logic [7:0] act_cfg;
        logic [7:0] pin_one;
        logic [7:0] pin_two;
        mei_power_e power;
        logic impact_sel;
        logic [1:0] timing;
        mei_seek_e seek;
        logic wait_svc;
        logic awake;
        logic flag_act;
        logic flag_still;
        logic flag_warn;
        logic flag_rdy;
        logic rdy_pend;
        logic [11:0] sample;
        logic rd_ack;
        logic [31:0] rdata;
    } mei_state_s;
endpackage
`default_nettype wire

// ==== mei_top.sv ====
// Purpose: Activity sequencing, status flags and interrupt pin routing
// Assumes: Detector pulses and sample strobe are synchronous to mclk_i
// Notes: Data reads are two-cycle Avalon reads; a read stretches over its wait cycle
//
// The Avalon-MM interface to the registers was left to the implementer.
`default_nettype none

// Functional notes
// - Linked: after activity, seek only inactivity.
// - Linked: after inactivity, seek only activity.
// - Linked: next detection waits until host reads event status.
// - Loop: alternate as linked, no waiting for service.
// - Autosleep: wake-up seeks activity, measure seeks inactivity, then wake-up.
// - Autosleep only starts after host writes wake-up mode.
// - Awake flag high in measurement mode for default or autosleep.
// - Linked/loop: awake set on activity, cleared on inactivity.
// - Warning threshold separate, ignored by sequencing and awake flag.
// - Warning single-sample, shares ref setting, routes to pin two only.
// - Instant-on gives no data; selected impact level switches to measurement.
// - Never back to instant-on alone; host writes measure then instant-on.
// - Per-pin routing; pin asserts OR of routed sources.
// - Pin with no sources is high-Z; both high-Z after reset.
// - Pins active high; polarity-low bit makes a pin active low.
// - Event status read clears activity, inactivity, warning flags.
// - Default mode, timer zero: flag kept until standby and measure restart.
// - Reading data registers clears sample-ready.
// - External timebase or triggered sampling turns pin into input, no interrupts.
// - Event bits set when their detection occurs.
// - Sample-ready set on new data, cleared at start of data read.
// - New data during a read sets sample-ready only after the read.
// - Wake-up uses single-sample activity and returns to measurement.
module mei_top (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic sample_valid_i,
    input wire logic [11:0] sample_i,
    input wire logic act_det_i,
    input wire logic act_single_i,
    input wire logic still_det_i,
    input wire logic [11:0] warn_mag_i,
    input wire logic impact_lo_i,
    input wire logic impact_hi_i,
    output logic warn_ref_o,
    output logic impact_sel_o,
    output logic data_en_o,
    output logic [1:0] power_mode_o,
    output logic irq_pin_one_o,
    output logic irq_pin_one_oe_o,
    output logic irq_pin_two_o,
    output logic irq_pin_two_oe_o
);
    mei_pkg::mei_state_s st;
    mei_pkg::mei_state_s next_st;
    logic rst_n;

    // -----------------------------------------------------------------
    // Reset release through two flops
    // -----------------------------------------------------------------
    logic [1:0] rst_ff;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_ff <= 2'b00;
        end else begin
            rst_ff <= {rst_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_ff[1];

    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                           input logic be);
        wr_byte = be ? d[7:0] : old;
    endfunction

    // Pin level for a route register and its status vector
    function automatic logic pin_level(input logic [7:0] rt, input logic [4:0] src);
        pin_level = (|(rt[4:0] & src)) ^ rt[mei_pkg::RT_LOW];
    endfunction

    logic acc;
    logic rd_evt;
    logic rd_dat;
    logic in_read;
    logic lk_seq;
    logic svc_ok;
    logic act_ev;
    logic still_ev;
    logic warn_ev;
    logic [4:0] src;
    mei_pkg::mei_link_e link;
    mei_pkg::mei_det_s det;

    assign link = mei_pkg::mei_link_e'(st.act_cfg[1:0]);
    assign det = '{act: act_det_i, still: still_det_i, impact_lo: impact_lo_i,
                   impact_hi: impact_hi_i, mag: warn_mag_i};
    assign acc = avs_read_i | avs_write_i;
    assign rd_evt = avs_read_i && !st.rd_ack && avs_address_i == mei_pkg::REG_EVT_STATUS;
    assign rd_dat = avs_read_i && avs_address_i == mei_pkg::REG_DATA;
    assign in_read = rd_dat;
    assign lk_seq = link != mei_pkg::MEI_LK_DEFAULT;

    always_comb begin
        next_st = st;
        next_st.rd_ack = acc && !st.rd_ack;
        svc_ok = (link != mei_pkg::MEI_LK_LINKED) || !st.wait_svc;
        // Wake-up mode uses single-sample activity regardless of timer
        act_ev = (st.power == mei_pkg::MEI_PW_WAKEUP) ? act_single_i : det.act;
        // Linked family runs only the detector it is seeking
        if (lk_seq) begin
            act_ev = act_ev && st.seek == mei_pkg::MEI_SEEK_ACT && svc_ok;
            still_ev = det.still && st.seek == mei_pkg::MEI_SEEK_STILL && svc_ok;
        end else begin
            still_ev = det.still;
        end
        if (st.power == mei_pkg::MEI_PW_STANDBY || st.power == mei_pkg::MEI_PW_INSTANT) begin
            act_ev = 1'b0;
            still_ev = 1'b0;
        end
        // Warning uses only its own threshold, single sample, no sequencing
        warn_ev = sample_valid_i && (st.power == mei_pkg::MEI_PW_MEASURE ||
                  st.power == mei_pkg::MEI_PW_WAKEUP) &&
                  det.mag > {4'h0, st.warn_thr};

        // Event status read clear, set wins over clear
        if (rd_evt) begin
            if (!(link == mei_pkg::MEI_LK_DEFAULT && st.act_cfg[mei_pkg::CF_ACT_T0])) begin
                next_st.flag_act = 1'b0;
            end
            if (!(link == mei_pkg::MEI_LK_DEFAULT && st.act_cfg[mei_pkg::CF_STILL_T0])) begin
                next_st.flag_still = 1'b0;
            end
            next_st.flag_warn = 1'b0;
            next_st.wait_svc = 1'b0;
        end
        if (act_ev) begin
            next_st.flag_act = 1'b1;
        end
        if (still_ev) begin
            next_st.flag_still = 1'b1;
        end
        if (warn_ev) begin
            next_st.flag_warn = 1'b1;
        end

        // Sequencing and awake state
        if (lk_seq && act_ev) begin
            next_st.seek = mei_pkg::MEI_SEEK_STILL;
            next_st.wait_svc = 1'b1;
        end
        if (lk_seq && still_ev) begin
            next_st.seek = mei_pkg::MEI_SEEK_ACT;
            next_st.wait_svc = 1'b1;
        end
        if (link == mei_pkg::MEI_LK_LINKED || link == mei_pkg::MEI_LK_LOOP) begin
            if (act_ev) begin
                next_st.awake = 1'b1;
            end else if (still_ev) begin
                next_st.awake = 1'b0;
            end
        end

        // Automatic power transitions
        if (st.power == mei_pkg::MEI_PW_WAKEUP && act_ev) begin
            next_st.power = mei_pkg::MEI_PW_MEASURE;
        end
        if (st.power == mei_pkg::MEI_PW_MEASURE && still_ev &&
            link == mei_pkg::MEI_LK_AUTOSLEEP && st.rst_sync[0]) begin
            next_st.power = mei_pkg::MEI_PW_WAKEUP;
        end
        if (st.power == mei_pkg::MEI_PW_INSTANT &&
            (st.impact_sel ? det.impact_hi : det.impact_lo)) begin
            next_st.power = mei_pkg::MEI_PW_MEASURE;
        end

        // Sample-ready: cleared at read start, set deferred past the read
        if (sample_valid_i && st.power == mei_pkg::MEI_PW_MEASURE) begin
            next_st.sample = sample_i;
            next_st.rdy_pend = 1'b1;
        end
        if (in_read) begin
            next_st.flag_rdy = 1'b0;
        end else if (st.rdy_pend || (sample_valid_i &&
                     st.power == mei_pkg::MEI_PW_MEASURE)) begin
            next_st.flag_rdy = 1'b1;
            next_st.rdy_pend = 1'b0;
        end

        // Register writes, applied on the acknowledge cycle
        if (avs_write_i && st.rd_ack) begin
            unique case (avs_address_i)
                mei_pkg::REG_WARN_THR: next_st.warn_thr =
                    wr_byte(st.warn_thr, avs_writedata_i, avs_byteenable_i[0]);
                mei_pkg::REG_ACT_CFG: next_st.act_cfg =
                    wr_byte(st.act_cfg, avs_writedata_i, avs_byteenable_i[0]);
                mei_pkg::REG_PIN_ONE: next_st.pin_one =
                    wr_byte(st.pin_one, avs_writedata_i, avs_byteenable_i[0]);
                mei_pkg::REG_PIN_TWO: next_st.pin_two =
                    wr_byte(st.pin_two, avs_writedata_i, avs_byteenable_i[0]);
                mei_pkg::REG_TIMING: if (avs_byteenable_i[0]) begin
                    next_st.timing = avs_writedata_i[1:0];
                end
                mei_pkg::REG_POWER: if (avs_byteenable_i[0]) begin
                    next_st.impact_sel = avs_writedata_i[mei_pkg::PW_IMPACT];
                    next_st.power = mei_pkg::mei_power_e'(avs_writedata_i[1:0]);
                    // Host-written wake-up arms autosleep
                    next_st.rst_sync[0] =
                        avs_writedata_i[1:0] == mei_pkg::MEI_PW_WAKEUP;
                    if (avs_writedata_i[1:0] == mei_pkg::MEI_PW_INSTANT &&
                        st.power != mei_pkg::MEI_PW_MEASURE &&
                        st.power != mei_pkg::MEI_PW_INSTANT) begin
                        next_st.power = st.power;
                    end
                    if (st.power == mei_pkg::MEI_PW_STANDBY &&
                        avs_writedata_i[1:0] == mei_pkg::MEI_PW_MEASURE) begin
                        next_st.flag_act = 1'b0;
                        next_st.flag_still = 1'b0;
                        next_st.seek = mei_pkg::MEI_SEEK_ACT;
                        next_st.wait_svc = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (link == mei_pkg::MEI_LK_DEFAULT || link == mei_pkg::MEI_LK_AUTOSLEEP) begin
            next_st.awake = next_st.power == mei_pkg::MEI_PW_MEASURE;
        end

        // Read data, one wait cycle then acknowledge
        next_st.rdata = mei_pkg::ZERO32;
        if (avs_read_i && !st.rd_ack) begin
            unique case (avs_address_i)
                mei_pkg::REG_DEV_STATUS: next_st.rdata = {27'h0, st.awake, 3'h0, st.flag_rdy};
                mei_pkg::REG_EVT_STATUS: next_st.rdata =
                    {28'h0, st.flag_warn, st.flag_still, st.flag_act, 1'b0};
                mei_pkg::REG_DATA: next_st.rdata = {20'h0, st.sample};
                mei_pkg::REG_WARN_THR: next_st.rdata = {24'h0, st.warn_thr};
                mei_pkg::REG_ACT_CFG: next_st.rdata = {24'h0, st.act_cfg};
                mei_pkg::REG_PIN_ONE: next_st.rdata = {24'h0, st.pin_one};
                mei_pkg::REG_PIN_TWO: next_st.rdata = {24'h0, st.pin_two};
                mei_pkg::REG_POWER: next_st.rdata = {29'h0, st.impact_sel, st.power};
                mei_pkg::REG_TIMING: next_st.rdata = {30'h0, st.timing};
                default: next_st.rdata = mei_pkg::ZERO32;
            endcase
        end else if (st.rd_ack) begin
            next_st.rdata = st.rdata;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // -----------------------------------------------------------------
    // Pins and outputs
    // -----------------------------------------------------------------
    assign src = {st.awake, st.flag_warn, st.flag_still, st.flag_act, st.flag_rdy};
    // Warning route bit is ignored on pin one, for enable and level alike
    logic [7:0] rt_one;
    assign rt_one = {st.pin_one[7:4], 1'b0, st.pin_one[2:0]};
    assign irq_pin_one_oe_o = (|rt_one[4:0]) && !st.timing[mei_pkg::TM_EXTCLK];
    assign irq_pin_two_oe_o = (|st.pin_two[4:0]) && !st.timing[mei_pkg::TM_SYNC];
    assign irq_pin_one_o = pin_level(rt_one, src);
    assign irq_pin_two_o = pin_level(st.pin_two, src);
    assign avs_waitrequest_o = acc && !st.rd_ack;
    assign avs_readdata_o = st.rdata;
    assign warn_ref_o = st.act_cfg[mei_pkg::CF_REF];
    assign impact_sel_o = st.impact_sel;
    assign data_en_o = st.power == mei_pkg::MEI_PW_MEASURE;
    assign power_mode_o = st.power;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    hiz_reset_a: assert property (@(posedge mclk_i)
        !rst_n |-> !irq_pin_one_oe_o && !irq_pin_two_oe_o)
        else $error("pin driven in reset");
    warn_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        rd_evt && !warn_ev |=> !st.flag_warn)
        else $error("warning flag not cleared");
    rdy_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        rd_dat |=> !st.flag_rdy)
        else $error("sample-ready not cleared");
    instant_exit_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        st.power != mei_pkg::MEI_PW_INSTANT && !(avs_write_i && st.rd_ack) |=>
        st.power != mei_pkg::MEI_PW_INSTANT)
        else $error("instant-on entered alone");
    act_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        act_ev |=> st.flag_act)
        else $error("activity flag not set");
    awake_meas_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        link == mei_pkg::MEI_LK_DEFAULT |-> st.awake == (st.power == mei_pkg::MEI_PW_MEASURE)
        || $changed(st.act_cfg) || $changed(st.power))
        else $error("awake flag mismatch");
    link_seek_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        lk_seq && still_ev |=> st.seek == mei_pkg::MEI_SEEK_ACT)
        else $error("seek not flipped");
    pin_ext_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
        st.timing[mei_pkg::TM_EXTCLK] |-> !irq_pin_one_oe_o)
        else $error("pin one driven as clock");
endmodule
`default_nettype wire

// ==== mei_top_bench.sv ====
// Purpose: Self-checking bench for the motion event sequencing and interrupt pins
// Assumes: Detector inputs are one-cycle pulses; registers sit in the low byte
// Notes: Each scenario leaves the block in measurement mode; all but t_linked leave default linking
`default_nettype none
module mei_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SMP = 0, ACT = 1, ONE = 2, STILL = 3, ILO = 4, IHI = 5;
    logic mclk, arst_n, read, write, waitreq, warn_ref, impact_sel, data_en;
    logic p1, p1oe, p2, p2oe;
    logic [1:0] pmode, wire_lv;
    logic [5:0] ev;
    logic [7:0] address;
    logic [11:0] sample, warn_mag;
    logic [31:0] wdata, rdata;
    int failures = 0;
    int compares = 0;
    mei_top dut (
        .mclk_i(mclk), .arst_n_i(arst_n), .avs_address_i(address), .avs_read_i(read),
        .avs_write_i(write), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .sample_valid_i(ev[0]),
        .sample_i(sample), .act_det_i(ev[1]), .act_single_i(ev[2]), .still_det_i(ev[3]),
        .warn_mag_i(warn_mag), .impact_lo_i(ev[4]), .impact_hi_i(ev[5]),
        .warn_ref_o(warn_ref), .impact_sel_o(impact_sel), .data_en_o(data_en),
        .power_mode_o(pmode), .irq_pin_one_o(p1), .irq_pin_one_oe_o(p1oe),
        .irq_pin_two_o(p2), .irq_pin_two_oe_o(p2oe)
    );
    mei_host_model host (
        .mclk_i(mclk), .wait_i(waitreq), .rdata_i(rdata), .pin_i({p2, p1}),
        .oe_i({p2oe, p1oe}), .address_o(address), .read_o(read), .write_o(write),
        .wdata_o(wdata), .wire_o(wire_lv)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic give_up();
        failures++;
        wrap_up();
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic ok;
        host.xfer(1'b1, a, {24'h00_0000, d}, q, ok);
        if (!ok) give_up();
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic ok;
        host.xfer(1'b0, a, 32'h0000_0000, q, ok);
        if (!ok) give_up();
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
        logic [31:0] q;
        rd(a, q);
        chk(q[15:0] & m, e);
    endtask
    // Registered outputs need a cycle after the causing edge to land
    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask
    task automatic pchk(input int n, input logic [15:0] e);
        settle();
        chk(n ? 16'({p2oe, wire_lv[1]}) : 16'({p1oe, wire_lv[0]}), e);
    endtask
    task automatic pulse(input int b);
        @(posedge mclk);
        ev <= 6'h01 << b;
        @(posedge mclk);
        ev <= 6'h00;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic mode(input logic [15:0] e);
        settle();
        chk(16'(pmode), e);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_route();
        chk(16'({p2oe, p1oe}), 16'h0000);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0000);
        rchk(8'hFC, 16'hFFFF, 16'h0000);
        wr(mei_pkg::REG_POWER, 8'h03);
        wr(mei_pkg::REG_PIN_ONE, 8'h02);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0010);
        pulse(ACT);
        repeat (6) @(posedge mclk);
        pchk(0, 16'h0003);
        wr(mei_pkg::REG_PIN_ONE, 8'h86);
        pchk(0, 16'h0002);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h000E, 16'h0002);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h000E, 16'h0000);
        pchk(0, 16'h0003);
        pulse(STILL);
        pchk(0, 16'h0002);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h000E, 16'h0004);
        wr(mei_pkg::REG_PIN_ONE, 8'h00);
        pchk(0, 16'h0001);
        $display("t_route done");
    endtask
    task automatic t_warn();
        wr(mei_pkg::REG_ACT_CFG, 8'h04);
        settle();
        chk(16'(warn_ref), 16'h0001);
        wr(mei_pkg::REG_ACT_CFG, 8'h00);
        wr(mei_pkg::REG_WARN_THR, 8'h10);
        wr(mei_pkg::REG_PIN_ONE, 8'h08);
        wr(mei_pkg::REG_PIN_TWO, 8'h08);
        warn_mag <= 12'hFFF;
        pulse(SMP);
        pchk(1, 16'h0003);
        chk(16'({p1oe, p1}), 16'h0000);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0010);
        warn_mag <= 12'h000;
        rchk(mei_pkg::REG_EVT_STATUS, 16'h000E, 16'h0008);
        pulse(SMP);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h000E, 16'h0000);
        pchk(1, 16'h0002);
        wr(mei_pkg::REG_PIN_TWO, 8'h00);
        $display("t_warn done");
    endtask
    task automatic t_hold();
        wr(mei_pkg::REG_ACT_CFG, 8'h08);
        pulse(ACT);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0002, 16'h0002);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0002, 16'h0002);
        wr(mei_pkg::REG_POWER, 8'h00);
        wr(mei_pkg::REG_POWER, 8'h03);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0002, 16'h0000);
        wr(mei_pkg::REG_ACT_CFG, 8'h00);
        $display("t_hold done");
    endtask
    task automatic t_linked();
        wr(mei_pkg::REG_ACT_CFG, 8'h01);
        pulse(ACT);
        pulse(STILL);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0010);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0006, 16'h0002);
        pulse(ACT);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0006, 16'h0000);
        pulse(STILL);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0000);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0006, 16'h0004);
        pulse(STILL);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0006, 16'h0000);
        pulse(ACT);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0010);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0006, 16'h0002);
        wr(mei_pkg::REG_ACT_CFG, 8'h02);
        pulse(STILL);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0000);
        pulse(ACT);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0010);
        rchk(mei_pkg::REG_EVT_STATUS, 16'h0006, 16'h0006);
        $display("t_linked done");
    endtask
    task automatic t_auto();
        logic ok;
        wr(mei_pkg::REG_ACT_CFG, 8'h03);
        pulse(STILL);
        mode(16'h0003);
        host.arm_wake(ok);
        if (!ok) give_up();
        mode(16'h0001);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0000);
        pulse(ONE);
        mode(16'h0003);
        chk(16'(data_en), 16'h0001);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0010, 16'h0010);
        pulse(STILL);
        mode(16'h0001);
        wr(mei_pkg::REG_ACT_CFG, 8'h00);
        wr(mei_pkg::REG_POWER, 8'h02);
        mode(16'h0001);
        for (int s = 0; s < 2; s++) begin
            host.arm_instant(s[0], ok);
            if (!ok) give_up();
            mode(16'h0002);
            chk(16'({impact_sel, data_en}), 16'(s * 2));
            pulse(s ? ILO : IHI);
            mode(16'h0002);
            pulse(s ? IHI : ILO);
            repeat (20) @(posedge mclk);
            mode(16'h0003);
        end
        $display("t_auto done");
    endtask
    task automatic t_ready();
        logic [31:0] q;
        wr(mei_pkg::REG_PIN_ONE, 8'h01);
        pulse(SMP);
        pchk(0, 16'h0003);
        rchk(mei_pkg::REG_DATA, 16'h0FFF, 16'h05A5);
        pchk(0, 16'h0002);
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0001, 16'h0000);
        fork
            rd(mei_pkg::REG_DATA, q);
            pulse(SMP);
        join
        rchk(mei_pkg::REG_DEV_STATUS, 16'h0001, 16'h0001);
        wr(mei_pkg::REG_PIN_TWO, 8'h01);
        wr(mei_pkg::REG_TIMING, 8'h02);
        pchk(0, 16'h0001);
        pchk(1, 16'h0003);
        wr(mei_pkg::REG_TIMING, 8'h01);
        pchk(1, 16'h0001);
        pchk(0, 16'h0003);
        wr(mei_pkg::REG_TIMING, 8'h00);
        $display("t_ready done");
    endtask
    initial begin
        arst_n = 1'b0;
        ev = 6'h00;
        sample = 12'h5A5;
        warn_mag = 12'h000;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_route();
        t_warn();
        t_hold();
        t_linked();
        t_auto();
        t_ready();
        wrap_up();
    end
endmodule
`default_nettype wire
